/* File: shared/fte_pkg.sv */
package fte_pkg;
  // ----------------------------------------------------------------
  // Vector numbers and layout constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  VEC_BUS_ERR   = 8'h02;
  localparam logic [7:0]  VEC_ADDR_ERR  = 8'h03;
  localparam logic [7:0]  VEC_ILLEGAL   = 8'h04;
  localparam logic [7:0]  VEC_DIV_ZERO  = 8'h05;
  localparam logic [7:0]  VEC_BOUNDS    = 8'h06;
  localparam logic [7:0]  VEC_CONDTRAP  = 8'h07;
  localparam logic [7:0]  VEC_LINE_A    = 8'h0A;
  localparam logic [7:0]  VEC_LINE_F    = 8'h0B;
  localparam logic [7:0]  VEC_TRAP_BASE = 8'h20;
  localparam int          VEC_SHIFT     = 2;
  localparam logic [3:0]  OPC_LINE_A    = 4'hA;
  localparam logic [3:0]  OPC_LINE_F    = 4'hF;
  localparam logic [2:0]  OPC_CPID_NONE = 3'h0;
  localparam int          SR_S_BIT      = 13;
  localparam int          SR_T0_BIT     = 14;
  localparam int          SR_T1_BIT     = 15;
  localparam logic [3:0]  FMT_NORMAL    = 4'h0;
  localparam logic [3:0]  FMT_TRAP_ADDR = 4'h2;
  localparam logic [3:0]  FMT_SHORT     = 4'hA;
  localparam logic [3:0]  FMT_LONG      = 4'hB;
  localparam logic [31:0] VBR_RESET     = 32'h0000_0000;
  localparam logic [3:0]  REG_VBR       = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_CTRL      = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TK_NONE, TK_TRAP, TK_COND, TK_OVF, TK_BOUND, TK_DIV
  } fte_tkind_type;

  typedef enum logic [1:0] {
    BK_DATA, BK_PREFETCH, BK_BREAKPOINT_INSTR, BK_COPROC
  } fte_bkind_type;

  typedef enum {ST_IDLE, ST_STACK, ST_VECTOR, ST_REFILL, ST_HALT} fte_state_type;

  typedef struct packed {
    logic          valid;
    logic [15:0]   opcode;
    logic          illegal;
    logic          control_register_move_bad;
    logic          ext_undef;
    fte_tkind_type kind;
    logic          cond_fail;
    logic          divisor_zero;
    logic [3:0]    trap_n;
  } fte_dec_type;

  typedef struct packed {
    logic [7:0]  vector;
    logic [3:0]  fmt;
    logic [31:0] stacked_pc;
    logic [15:0] sr_copy;
    logic        has_addr;
    logic [31:0] instr_addr;
  } fte_frame_type;
endpackage

/* File: core/fte_core.sv */
`timescale 1ns/1ps
// Operation
// - Data access bus error starts exception processing right away.
// - Prefetch bus error waits until the faulted words are used.
// - Fault entry copies status, sets supervisor, clears both trace bits.
// - Bus error uses vector 2 and stacks offset, PC and status copy.
// - Bus error stacks the PC of the instruction executing at detection.
// - Short frame at instruction boundary, long frame mid-instruction.
// - Bus error during fault processing or return reload halts the core.
// - Only reset leaves the double fault halt.
// - Odd prefetch address raises address error without a bus cycle.
// - Address error follows bus error path with vector 3.
// - Address error during fault processing is a double fault.
// - Trap uses 32 plus n; conditional traps fire only on failure.
// - Divides trap when the divisor is zero.
// - Traps set supervisor, clear trace; pending trace follows the return.
// - Traps stack the address of the following instruction.
// - Traps other than the plain trap also stack the trapping address.
// - Invalid opcode or bad control register move uses vector 4.
// - Breakpoint acknowledge ended by bus error gives illegal instruction.
// - Top nibble 1010 opcodes raise vector 10.
// - Line F with coprocessor 0 and bad extension: vector 11 or privilege.
// - Coprocessor cycle ended by bus error gives line F exception.
// - Illegal opcodes are not executed and stack their own address.
// - Vector address is vector base plus four times the vector number.
// - Halt output is asserted while halted by a double fault.
module fte_core
  import fte_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [3:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_we_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          bus_error_in_i,
  input  wire fte_bkind_type bus_kind_i,
  input  wire logic          pf_use_i,
  input  wire logic          pf_flush_i,
  input  wire logic          fetch_req_i,
  input  wire logic          fetch_odd_i,
  output logic               fetch_go_o,
  input  wire fte_dec_type   dec_i,
  input  wire logic [15:0]   status_register_i,
  input  wire logic [31:0]   cur_pc_i,
  input  wire logic [31:0]   next_pc_i,
  input  wire logic          at_boundary_i,
  input  wire logic          reset_seq_i,
  input  wire logic          rte_reload_i,
  input  wire logic          rte_done_i,
  output logic [15:0]        status_register_o,
  output logic               sr_load_o,
  output logic               priv_req_o,
  output fte_frame_type      frame_o,
  output logic               frame_valid_o,
  input  wire logic          frame_ready_i,
  output logic [31:0]        vec_addr_o,
  output logic               vec_req_o,
  input  wire logic          vec_ack_i,
  input  wire logic [31:0]   vec_pc_i,
  output logic [31:0]        new_pc_o,
  output logic               refill_req_o,
  input  wire logic          refill_done_i,
  output logic               trace_after_return_o,
  output logic               halt_o
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  fte_state_type state_r;
  logic [31:0]   vbr_r;
  logic          defer_pf_r;
  logic          pf_pend_r;
  logic          fault_kind_r;
  logic          trace_defer_r;
  logic [15:0]   sr_nxt;

  wire logic busy   = (state_r != ST_IDLE) && (state_r != ST_HALT);
  wire logic idle   = (state_r == ST_IDLE);
  wire logic bus_error_in_d = bus_error_in_i && (bus_kind_i == BK_DATA);
  wire logic bus_error_in_p = bus_error_in_i && (bus_kind_i == BK_PREFETCH);
  wire logic odd_pf = fetch_req_i && fetch_odd_i;

  // A fault inside fault, reset or return-reload processing cannot be
  // stacked safely, so the core stops without touching memory.
  wire logic dbl_zone  = (busy && fault_kind_r) || reset_seq_i || rte_reload_i;
  wire logic dbl_fault = dbl_zone && (bus_error_in_i || odd_pf);

  // ----------------------------------------------------------------
  // Odd prefetch suppression
  // ----------------------------------------------------------------
  assign fetch_go_o = fetch_req_i && !fetch_odd_i && idle;

  // ----------------------------------------------------------------
  // Prefetch fault tracking
  // ----------------------------------------------------------------
  // With deferral off, a prefetch bus error is taken like a data error.
  wire logic pf_now = bus_error_in_p && !defer_pf_r;
  wire logic pf_hit = pf_use_i && (pf_pend_r || (bus_error_in_p && defer_pf_r));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pf_pend_r <= 1'b0;
    end else if (bus_error_in_p && defer_pf_r && !(pf_use_i && idle)) begin
      // A fault consumed in the cycle it arrives must not stay pending,
      // or it would be taken a second time on the next use.
      pf_pend_r <= 1'b1;
    end else if (pf_flush_i || (pf_hit && idle)) begin
      pf_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Decode exception selection
  // ----------------------------------------------------------------
  wire logic line_a  = dec_i.opcode[15:12] == OPC_LINE_A;
  wire logic line_f  = dec_i.opcode[15:12] == OPC_LINE_F;
  wire logic cp_zero = dec_i.opcode[11:9] == OPC_CPID_NONE;
  wire logic sup     = status_register_i[SR_S_BIT];
  wire logic f_undef = line_f && cp_zero && dec_i.ext_undef;
  wire logic cp_bus_error_in = bus_error_in_i && (bus_kind_i == BK_COPROC);
  wire logic bk_bus_error_in = bus_error_in_i && (bus_kind_i == BK_BREAKPOINT_INSTR);

  logic       dec_hit;
  logic [7:0] dec_vec;
  logic       dec_trap;
  always_comb begin
    dec_hit  = 1'b0;
    dec_vec  = VEC_ILLEGAL;
    dec_trap = 1'b0;
    if (bk_bus_error_in) begin
      dec_hit = 1'b1;
    end else if (cp_bus_error_in) begin
      dec_hit = 1'b1;
      dec_vec = VEC_LINE_F;
    end else if (dec_i.valid) begin
      if (line_a) begin
        dec_hit = 1'b1;
        dec_vec = VEC_LINE_A;
      end else if (f_undef) begin
        dec_hit = sup;
        dec_vec = VEC_LINE_F;
      end else if (dec_i.illegal || dec_i.control_register_move_bad) begin
        dec_hit = 1'b1;
      end else begin
        dec_trap = 1'b1;
        case (dec_i.kind)
          TK_TRAP: begin
            dec_hit = 1'b1;
            dec_vec = VEC_TRAP_BASE + {4'h0, dec_i.trap_n};
          end
          TK_COND, TK_OVF: begin
            dec_hit = dec_i.cond_fail;
            dec_vec = VEC_CONDTRAP;
          end
          TK_BOUND: begin
            dec_hit = dec_i.cond_fail;
            dec_vec = VEC_BOUNDS;
          end
          TK_DIV: begin
            dec_hit = dec_i.divisor_zero;
            dec_vec = VEC_DIV_ZERO;
          end
          default: begin
            dec_trap = 1'b0;
          end
        endcase
      end
    end
  end

  // Privilege checks belong elsewhere; this only flags the user-state case.
  assign priv_req_o = idle && dec_i.valid && !line_a && f_undef && !sup;

  // ----------------------------------------------------------------
  // Entry arbitration
  // ----------------------------------------------------------------
  wire logic take_bus_error_in = idle && (bus_error_in_d || pf_now || pf_hit) && !dbl_fault;
  wire logic take_addr = idle && odd_pf && !dbl_fault && !take_bus_error_in;
  wire logic take_dec  = idle && dec_hit && !dbl_fault && !take_bus_error_in && !take_addr;
  // A bus error while stacking a trap frame is restarted as a bus fault.
  wire logic take_rest = busy && !fault_kind_r && bus_error_in_i;
  wire logic take_flt  = take_bus_error_in || take_addr || take_rest;
  wire logic take_any  = take_flt || take_dec;

  always_comb begin
    sr_nxt             = status_register_i;
    sr_nxt[SR_S_BIT]   = 1'b1;
    sr_nxt[SR_T0_BIT]  = 1'b0;
    sr_nxt[SR_T1_BIT]  = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_register_o <= 16'h0000;
      sr_load_o         <= 1'b0;
    end else begin
      sr_load_o <= take_any && !take_rest;
      if (take_any && !take_rest) begin
        status_register_o <= sr_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame contents
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_o      <= '0;
      fault_kind_r <= 1'b0;
    end else if (take_flt) begin
      fault_kind_r       <= 1'b1;
      frame_o.vector     <= take_addr ? VEC_ADDR_ERR : VEC_BUS_ERR;
      frame_o.stacked_pc <= cur_pc_i;
      frame_o.fmt        <= (at_boundary_i && !take_rest) ? FMT_SHORT : FMT_LONG;
      frame_o.has_addr   <= 1'b0;
      if (!take_rest) begin
        frame_o.sr_copy <= status_register_i;
      end
    end else if (take_dec) begin
      fault_kind_r       <= 1'b0;
      frame_o.vector     <= dec_vec;
      frame_o.sr_copy    <= status_register_i;
      frame_o.stacked_pc <= dec_trap ? next_pc_i : cur_pc_i;
      frame_o.has_addr   <= dec_trap && (dec_i.kind != TK_TRAP);
      frame_o.instr_addr <= cur_pc_i;
      frame_o.fmt        <= (dec_trap && (dec_i.kind != TK_TRAP)) ? FMT_TRAP_ADDR
                                                                  : FMT_NORMAL;
    end
  end

  // ----------------------------------------------------------------
  // Deferred trace of a trapping instruction
  // ----------------------------------------------------------------
  wire logic tr_on = status_register_i[SR_T0_BIT] || status_register_i[SR_T1_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trace_defer_r <= 1'b0;
    end else if (take_dec && dec_trap && tr_on) begin
      trace_defer_r <= 1'b1;
    end else if (rte_done_i) begin
      trace_defer_r <= 1'b0;
    end
  end
  assign trace_after_return_o = trace_defer_r && rte_done_i;

  // ----------------------------------------------------------------
  // Entry sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (dbl_fault) begin
            state_r <= ST_HALT;
          end else if (take_any) begin
            state_r <= ST_STACK;
          end
        end
        ST_STACK, ST_VECTOR, ST_REFILL: begin
          if (dbl_fault) begin
            state_r <= ST_HALT;
          end else if (take_rest) begin
            state_r <= ST_STACK;
          end else if (state_r == ST_STACK && frame_ready_i) begin
            state_r <= ST_VECTOR;
          end else if (state_r == ST_VECTOR && vec_ack_i) begin
            state_r <= ST_REFILL;
          end else if (state_r == ST_REFILL && refill_done_i) begin
            state_r <= ST_IDLE;
          end
        end
        ST_HALT: begin
          state_r <= ST_HALT;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      new_pc_o <= 32'h0000_0000;
    end else if (state_r == ST_VECTOR && vec_ack_i) begin
      new_pc_o <= vec_pc_i;
    end
  end

  assign frame_valid_o = (state_r == ST_STACK);
  assign vec_req_o     = (state_r == ST_VECTOR);
  assign refill_req_o  = (state_r == ST_REFILL);
  assign halt_o        = (state_r == ST_HALT);
  assign vec_addr_o    = vbr_r + (32'(frame_o.vector) << VEC_SHIFT);

  // ----------------------------------------------------------------
  // Wishbone register slave
  // ----------------------------------------------------------------
  wire logic wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vbr_r      <= VBR_RESET;
      defer_pf_r <= 1'b1;
    end else if (wb_hit && wb_we_i) begin
      if (wb_adr_i == REG_VBR) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            vbr_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
      end else if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        defer_pf_r <= wb_dat_i[0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit) begin
      case (wb_adr_i)
        REG_VBR:    wb_dat_o <= vbr_r;
        REG_STATUS: wb_dat_o <= {18'h0, pf_pend_r, trace_defer_r, frame_o.fmt,
                                 frame_o.vector[5:0], busy, halt_o};
        REG_CTRL:   wb_dat_o <= {31'h0, defer_pf_r};
        default:    wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence entry_s;
    frame_valid_o ##1 1'b1;
  endsequence

  vec_addr_calc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_req_o |-> vec_addr_o == vbr_r + 32'(frame_o.vector) * 32'd4)
    else $error("vector address mismatch");

  halt_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_o |=> halt_o) else $error("halt released without reset");

  double_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy && fault_kind_r && bus_error_in_i) |=> halt_o && !frame_valid_o)
    else $error("double fault did not halt");

  sr_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sr_load_o |-> status_register_o[SR_S_BIT] && !status_register_o[SR_T0_BIT]
                  && !status_register_o[SR_T1_BIT])
    else $error("entry status wrong");

  odd_fetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle && odd_pf && !dbl_zone && !take_bus_error_in) |-> !fetch_go_o ##1 frame_valid_o
                                      && frame_o.vector == VEC_ADDR_ERR)
    else $error("odd prefetch not trapped");

  data_bus_error_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle && bus_error_in_d && !dbl_zone) |=> entry_s and (frame_o.vector == VEC_BUS_ERR))
    else $error("data bus error not taken");

  trap_vector_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take_dec && dec_i.kind == TK_TRAP && dec_trap
    |=> frame_o.vector == VEC_TRAP_BASE + {4'h0, $past(dec_i.trap_n)}
        && frame_o.stacked_pc == $past(next_pc_i))
    else $error("trap vector or pc wrong");

  refill_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (vec_req_o && vec_ack_i && !dbl_fault && !take_rest)
    |=> refill_req_o && new_pc_o == $past(vec_pc_i))
    else $error("refill did not follow vector fetch");

  divide_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take_dec && dec_i.kind == TK_DIV && dec_trap) |=> frame_o.vector == VEC_DIV_ZERO
    && frame_o.has_addr)
    else $error("divide by zero vector wrong");
endmodule

/* File: test/fte_far_model.sv */
`timescale 1ns/1ps
module fte_far_model
  import fte_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        stall_i,
  input  wire logic [3:0]  dly_i,
  input  wire logic        frame_valid_i,
  input  wire logic        vec_req_i,
  input  wire logic [31:0] vec_addr_i,
  input  wire logic        refill_req_i,
  output logic             frame_ready_o,
  output logic             vec_ack_o,
  output logic [31:0]      vec_pc_o,
  output logic             refill_done_o
);
  logic [3:0] wait_r;
  logic       req;

  assign req = frame_valid_i | vec_req_i | refill_req_i;

  // The vector word is only meaningful with its acknowledge; it holds while the delay counts and toggles otherwise.
  always_ff @(posedge clk_i) begin
    if (rst_i || stall_i || frame_ready_o || vec_ack_o || refill_done_o) begin
      wait_r        <= 4'h0;
      frame_ready_o <= 1'b0;
      vec_ack_o     <= 1'b0;
      refill_done_o <= 1'b0;
      vec_pc_o      <= rst_i ? 32'hA5A5_0F0F : ~vec_pc_o;
    end else if (req && wait_r != dly_i) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      frame_ready_o <= frame_valid_i;
      vec_ack_o     <= vec_req_i;
      vec_pc_o      <= vec_req_i ? ~vec_addr_i : ~vec_pc_o;
      refill_done_o <= refill_req_i;
    end
  end
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb
  import fte_pkg::*;
  ;
  int miscompares = 0;
  int cmp_count = 0;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, dly = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, vector_base_register = 32'h0, q;
  logic bus_error_in_i = 1'b0, pf_use_i = 1'b0, pf_flush_i = 1'b0, stall = 1'b0;
  logic fetch_req_i = 1'b0, fetch_odd_i = 1'b0, at_boundary_i = 1'b1;
  logic reset_seq_i = 1'b0, rte_reload_i = 1'b0, rte_done_i = 1'b0;
  fte_bkind_type bus_kind_i = BK_DATA;
  fte_dec_type dec_i = '0;
  logic [15:0] sr = 16'h8000;
  logic [31:0] cur_pc = 32'h0000_1000, next_pc = 32'h0000_1004;
  logic [31:0] wb_dat_o, vec_addr_o, vec_pc_i, new_pc_o;
  logic [15:0] status_register_o;
  fte_frame_type frame_o;
  logic wb_ack_o, fetch_go_o, sr_load_o, priv_req_o, frame_valid_o, frame_ready_i;
  logic vec_req_o, vec_ack_i, refill_req_o, refill_done_i, trace_after_return_o, halt_o;

  always #10 clk_i = ~clk_i;

  fte_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_error_in_i(bus_error_in_i),
    .bus_kind_i(bus_kind_i), .pf_use_i(pf_use_i), .pf_flush_i(pf_flush_i),
    .fetch_req_i(fetch_req_i), .fetch_odd_i(fetch_odd_i), .fetch_go_o(fetch_go_o),
    .dec_i(dec_i), .status_register_i(sr), .cur_pc_i(cur_pc), .next_pc_i(next_pc),
    .at_boundary_i(at_boundary_i), .reset_seq_i(reset_seq_i), .rte_reload_i(rte_reload_i),
    .rte_done_i(rte_done_i), .status_register_o(status_register_o), .sr_load_o(sr_load_o),
    .priv_req_o(priv_req_o), .frame_o(frame_o), .frame_valid_o(frame_valid_o),
    .frame_ready_i(frame_ready_i), .vec_addr_o(vec_addr_o), .vec_req_o(vec_req_o),
    .vec_ack_i(vec_ack_i), .vec_pc_i(vec_pc_i), .new_pc_o(new_pc_o),
    .refill_req_o(refill_req_o), .refill_done_i(refill_done_i),
    .trace_after_return_o(trace_after_return_o), .halt_o(halt_o));

  fte_far_model far (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .dly_i(dly),
    .frame_valid_i(frame_valid_o), .vec_req_i(vec_req_o), .vec_addr_i(vec_addr_o),
    .refill_req_i(refill_req_o), .frame_ready_o(frame_ready_i), .vec_ack_o(vec_ack_i),
    .vec_pc_o(vec_pc_i), .refill_done_o(refill_done_i));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task close_out;
    $display("mismatches %0d of %0d compares", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      close_out();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Kinds: 0 frame offered, 1 vector fetch, 2 refill, 3 back to idle.
  task wait_on(input int k);
    int n;
    n = 0;
    while (!((k == 0 && frame_valid_o === 1'b1) || (k == 1 && vec_req_o === 1'b1) ||
             (k == 2 && refill_req_o === 1'b1) || (k == 3 && frame_valid_o === 1'b0 &&
             vec_req_o === 1'b0 && refill_req_o === 1'b0)) && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 40) begin
      miscompares++;
      close_out();
    end
  endtask

  task entry(input logic [7:0] v, input logic [3:0] f, input logic [31:0] pc, input logic h);
    wait_on(0);
    chk("vector", frame_o.vector, v);
    chk("format", frame_o.fmt, f);
    chk("stacked pc", frame_o.stacked_pc, pc);
    chk("has addr", frame_o.has_addr, h);
    if (h) chk("instr addr", frame_o.instr_addr, cur_pc);
    chk("sr copy", frame_o.sr_copy, sr);
    chk("new sr", status_register_o, (sr | 16'h2000) & 16'h3FFF);
    chk("sr load", sr_load_o, 1'b1);
    wait_on(1);
    chk("vec addr", vec_addr_o, vector_base_register + {22'h0, v, 2'h0});
    wait_on(2);
    chk("new pc", new_pc_o, ~(vector_base_register + {22'h0, v, 2'h0}));
    wait_on(3);
  endtask

  task bus_error_in_ev(input fte_bkind_type k);
    @(posedge clk_i);
    bus_error_in_i <= 1'b1;
    bus_kind_i     <= k;
    @(posedge clk_i);
    bus_error_in_i <= 1'b0;
    #1;
  endtask

  task odd_ev;
    @(posedge clk_i);
    fetch_req_i <= 1'b1;
    fetch_odd_i <= 1'b1;
    #1;
    chk("no odd cycle", fetch_go_o, 1'b0);
    @(posedge clk_i);
    fetch_req_i <= 1'b0;
    fetch_odd_i <= 1'b0;
    #1;
  endtask

  task dec_ev(input fte_dec_type d);
    @(posedge clk_i);
    dec_i <= d;
    #1;
    @(posedge clk_i);
    dec_i <= '0;
    #1;
  endtask

  task pulse(input int k);
    @(posedge clk_i);
    pf_use_i   <= (k == 0);
    pf_flush_i <= (k == 1);
    rte_done_i <= (k >= 2);
    #1;
    if (k >= 2) chk("trace after return", trace_after_return_o, k == 2);
    @(posedge clk_i);
    pf_use_i   <= 1'b0;
    pf_flush_i <= 1'b0;
    rte_done_i <= 1'b0;
    #1;
  endtask

  task quiet;
    repeat (4) begin
      @(posedge clk_i);
      #1;
      chk("no entry", frame_valid_o, 1'b0);
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task s_regs;
    wb(REG_VBR, 1'b1, 32'h0000_4000);
    vector_base_register = 32'h0000_4000;
    wb(REG_VBR, 1'b0, 32'h0);
    chk("vbr", q, vector_base_register);
    wb(REG_STATUS, 1'b1, 32'hFFFF_FFFF);
    wb(REG_STATUS, 1'b0, 32'h0);
    chk("status", q, 32'h0);
    wb(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl", q, 32'h1);
    wb(4'hC, 1'b1, 32'hFFFF_FFFF);
    wb(4'hC, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask

  task s_faults;
    bus_error_in_ev(BK_DATA);
    chk("data fault at once", frame_valid_o, 1'b1);
    entry(VEC_BUS_ERR, FMT_SHORT, cur_pc, 1'b0);
    dly = 4'h3;
    at_boundary_i = 1'b0;
    @(posedge clk_i);
    fetch_req_i <= 1'b1;
    #1;
    chk("even fetch runs", fetch_go_o, 1'b1);
    odd_ev();
    chk("odd fault at once", frame_valid_o, 1'b1);
    entry(VEC_ADDR_ERR, FMT_LONG, cur_pc, 1'b0);
    dly = 4'h0;
    bus_error_in_ev(BK_PREFETCH);
    quiet();
    pulse(0);
    entry(VEC_BUS_ERR, FMT_LONG, cur_pc, 1'b0);
    bus_error_in_ev(BK_PREFETCH);
    pulse(1);
    pulse(0);
    quiet();
    wb(REG_CTRL, 1'b1, 32'h0);
    bus_error_in_ev(BK_PREFETCH);
    entry(VEC_BUS_ERR, FMT_LONG, cur_pc, 1'b0);
  endtask

  task s_trap;
    fte_tkind_type kinds [5];
    logic [7:0] vecs [5];
    fte_dec_type d;
    kinds = '{TK_TRAP, TK_COND, TK_OVF, TK_BOUND, TK_DIV};
    vecs = '{8'h2F, VEC_CONDTRAP, VEC_CONDTRAP, VEC_BOUNDS, VEC_DIV_ZERO};
    for (int i = 0; i < 5; i++) begin
      d = '0;
      d.valid = 1'b1;
      d.opcode = 16'h4E4F;
      d.kind = kinds[i];
      d.trap_n = 4'hF;
      if (i > 0) begin
        dec_ev(d);
        quiet();
      end
      d.cond_fail = 1'b1;
      d.divisor_zero = 1'b1;
      dec_ev(d);
      entry(vecs[i], (i > 0) ? FMT_TRAP_ADDR : FMT_NORMAL, next_pc, i > 0);
      pulse(2);
    end
  endtask

  task s_illegal;
    fte_dec_type d;
    for (int i = 0; i < 4; i++) begin
      d = '0;
      d.valid = 1'b1;
      d.opcode = (i == 2) ? 16'hA000 : (i == 3) ? 16'hF000 : 16'h4AFC;
      d.illegal = (i == 0);
      d.control_register_move_bad = (i == 1);
      d.ext_undef = (i == 3);
      sr = 16'hA000;
      dec_ev(d);
      entry((i == 2) ? VEC_LINE_A : (i == 3) ? VEC_LINE_F : VEC_ILLEGAL, FMT_NORMAL,
            cur_pc, 1'b0);
    end
    pulse(3);
    sr = 16'h0000;
    @(posedge clk_i);
    dec_i <= d;
    #1;
    chk("user line f", priv_req_o, 1'b1);
    @(posedge clk_i);
    dec_i <= '0;
    quiet();
    bus_error_in_ev(BK_BREAKPOINT_INSTR);
    entry(VEC_ILLEGAL, FMT_NORMAL, cur_pc, 1'b0);
    bus_error_in_ev(BK_COPROC);
    entry(VEC_LINE_F, FMT_NORMAL, cur_pc, 1'b0);
  endtask

  task s_halt;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_i);
      stall <= (c < 2);
      rte_reload_i <= (c == 2);
      reset_seq_i <= (c == 3);
      if (c < 2) bus_error_in_ev(BK_DATA);
      if (c[0]) odd_ev();
      else bus_error_in_ev(BK_DATA);
      chk("halt at once", halt_o, 1'b1);
      @(posedge clk_i);
      stall <= 1'b0;
      rte_reload_i <= 1'b0;
      reset_seq_i <= 1'b0;
      repeat (5) begin
        @(posedge clk_i);
        #1;
        chk("halted", halt_o, 1'b1);
        chk("frozen", frame_valid_o, 1'b0);
      end
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("halt cleared", halt_o, 1'b0);
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs();
    s_faults();
    s_trap();
    s_illegal();
    s_halt();
    close_out();
  end
endmodule
